// ==== pfs_pkg.sv ====
// ==========================================================================
// shared constants for the port pin-function select block
// ==========================================================================
package pfs_pkg;

  // port width and direction encoding
  localparam int PORT_W = 8; // bits per port
  localparam logic DIR_OUTPUT = 1'b1; // direction bit value for output

  // reset values
  localparam logic PIN_OUT_RST = 1'b0; // pin output value in reset
  localparam logic PIN_OE_RST = 1'b0; // no pin driven in reset
  localparam logic LEVEL_RST = 1'b1; // sampled pin level in reset

  // levels that a feed shows while its function is not selected
  localparam logic FEED_IDLE = 1'b1; // active-low inputs rest high
  localparam logic CLK_IDLE = 1'b0; // external clock rests low
  localparam logic STATUS_RST = 1'b0; // enable terms in reset

  // port 8 bit positions
  localparam int P8_TXD = 4; // serial 1 transmit
  localparam int P8_PWRDN = 3; // host power-down input
  localparam int P8_HOST_CLOCK_RUN_IO = 2; // host clock-run i/o
  localparam int P8_GATE_A20_OUT = 1; // gate a20 output
  localparam int P8_PME = 0; // power event output

  // port 9 bit positions
  localparam int P9_SDA = 7; // i2c 0 data
  localparam int P9_CLK = 6; // external clock input / clock output
  localparam int P9_IRQ_N = 6; // bits 5..0 carry interrupts
  localparam int P9_IRQ [0:5] = '{2, 1, 0, 12, 13, 14}; // irq per bit

  // interrupt numbers of single pins
  localparam int IRQ_P84 = 3; // pin 8-4
  localparam int IRQ_P97 = 15; // pin 9-7
  localparam int IRQ_N = 16; // interrupt inputs

  // port a bit positions
  localparam int PA_PS2_LO = 2; // lowest ps/2 pin
  localparam int PA_PS2_HI = 5; // highest ps/2 pin
  localparam int PA_OD_LO = 4; // lowest pin under i2c format select
  localparam int PA_OD_HI = 7; // highest pin under i2c format select
  localparam int KEY_BASE = 8; // key-scan input of pin a-0

  // port b bit positions
  localparam int PB_RTS = 7; // request to send
  localparam int PB_CTS = 6; // clear to send
  localparam int PB_DTR = 5; // data terminal ready
  localparam int PB_DSR = 4; // data set ready
  localparam int PB_DCD = 3; // carrier detect / pwm 1

endpackage : pfs_pkg

// ==== pfs_pin_cell.sv ====
`timescale 1ns/1ps
// ==========================================================================
// one port's output drivers and input samplers
// ==========================================================================
module pfs_pin_cell #(
  parameter int W = 8 // pins in this port
) (
  input wire logic clk, // system clock
  input wire logic srst, // synchronous reset, active high
  input wire logic [W-1:0] dir, // port direction bits
  input wire logic [W-1:0] data, // port output data
  input wire logic [W-1:0] fsel, // peripheral owns the pin
  input wire logic [W-1:0] fout, // peripheral output value
  input wire logic [W-1:0] foe, // peripheral drives the pin
  input wire logic [W-1:0] od, // drive low only
  input wire logic [W-1:0] pin_i, // pin level
  output logic [W-1:0] pin_o, // pin output value
  output logic [W-1:0] pin_oe, // pin output enable
  output logic [W-1:0] level // sampled pin level
);

  logic [W-1:0] next_pin_o; // value for the next edge
  logic [W-1:0] next_pin_oe; // enable for the next edge

  // ==========================================================================
  // function select and output format
  // ==========================================================================
  // input-only selections leave the buffer off
  always_comb begin
    logic drive;
    logic val;
    drive = 1'b0;
    val = 1'b0;
    next_pin_o = '0;
    next_pin_oe = '0;
    for (int i = 0; i < W; i++) begin
      if (fsel[i]) begin // peripheral function
        drive = foe[i];
        val = fout[i];
      end else begin // plain port
        drive = (dir[i] == pfs_pkg::DIR_OUTPUT);
        val = data[i];
      end
      if (od[i]) begin // pull low or release, never high
        next_pin_o[i] = 1'b0;
        next_pin_oe[i] = drive & ~val;
      end else begin
        next_pin_o[i] = val;
        next_pin_oe[i] = drive;
      end
    end
  end

  // outputs registered so the pads see no select glitches
  always_ff @(posedge clk) begin
    if (srst) begin
      pin_o <= {W{pfs_pkg::PIN_OUT_RST}};
      pin_oe <= {W{pfs_pkg::PIN_OE_RST}};
    end else begin
      pin_o <= next_pin_o;
      pin_oe <= next_pin_oe;
    end
  end

  // pin levels sampled each cycle for port reads; the feeds take their own sample
  always_ff @(posedge clk) begin
    if (srst) begin
      level <= {W{pfs_pkg::LEVEL_RST}};
    end else begin
      level <= pin_i;
    end
  end

endmodule : pfs_pin_cell

// ==== pfs_port_select.sv ====
`timescale 1ns/1ps
module pfs_port_select #(
  parameter int W = pfs_pkg::PORT_W // pins per port
) (
  input wire logic clk, // system clock
  input wire logic srst, // synchronous reset, active high
  // ==========================================================================
  // port 8
  // ==========================================================================
  input wire logic [W-1:0] port8_dir, // direction bits
  input wire logic [W-1:0] port8_data, // output data
  input wire logic [W-1:0] port8_pin_i, // pin levels
  output logic [W-1:0] port8_pin_o, // pin output values
  output logic [W-1:0] port8_pin_oe, // pin output enables
  output logic [W-1:0] port8_level, // sampled levels
  input wire logic serial1_transmit_enable, // serial 1 transmit on
  input wire logic serial1_transmit_out, // serial 1 transmit data
  input wire logic serial_fifo_host_enable, // serial fifo on host bus
  input wire logic host_channel4_enable, // host channel 4 on
  input wire logic host_channel3_enable, // host channel 3 on
  input wire logic host_channel2_enable, // host channel 2 on
  input wire logic host_channel1_enable, // host channel 1 on
  output logic host_bus_enable_term, // any host function on
  output logic host_power_down_in, // power-down to host logic
  input wire logic host_clock_run_out, // clock-run output value
  input wire logic host_clock_run_oe, // clock-run drive enable
  output logic host_clock_run_in, // clock-run level
  input wire logic fast_gate_a20_enable, // gate a20 on
  input wire logic gate_a20_out, // gate a20 value
  input wire logic power_event_enable, // power event on
  input wire logic power_event_out, // power event value
  // ==========================================================================
  // port 9
  // ==========================================================================
  input wire logic [W-1:0] port9_dir, // direction bits
  input wire logic [W-1:0] port9_data, // output data
  input wire logic [W-1:0] port9_pin_i, // pin levels
  output logic [W-1:0] port9_pin_o, // pin output values
  output logic [W-1:0] port9_pin_oe, // pin output enables
  output logic [W-1:0] port9_level, // sampled levels
  input wire logic i2c0_enable, // i2c 0 on
  input wire logic i2c0_data_out, // i2c 0 data, 0 pulls low
  output logic i2c0_data_line, // i2c 0 data level
  input wire logic ext_clock_select, // external clock select
  input wire logic ext_clock_enable, // external clock on
  output logic ext_clock_in, // external clock level
  input wire logic clock_out_value, // clock output value of pin 9-6
  input wire logic [15:0] irq_pin_select, // interrupt pin selects
  input wire logic [15:0] irq_enable, // interrupt enables
  output logic [15:0] irq_in, // interrupt levels, idle high
  // ==========================================================================
  // port a
  // ==========================================================================
  input wire logic [W-1:0] porta_dir, // direction bits
  input wire logic [W-1:0] porta_data, // output data
  input wire logic [W-1:0] porta_pin_i, // pin levels
  output logic [W-1:0] porta_pin_o, // pin output values
  output logic [W-1:0] porta_pin_oe, // pin output enables
  output logic [W-1:0] porta_level, // sampled levels
  input wire logic [15:8] keyscan_mask_bit, // key-scan masks
  output logic [15:8] keyscan_input, // key-scan levels, idle high
  input wire logic i2c_pin_format_select, // drive-low format a-7..a-4
  input wire logic ps2_pin_enable, // ps/2 owns a-5..a-2
  input wire logic [3:0] ps2_out, // ps/2 values, 0 pulls low
  output logic [3:0] ps2_line_in, // ps/2 levels
  // ==========================================================================
  // port b
  // ==========================================================================
  input wire logic [W-1:0] portb_dir, // direction bits
  input wire logic [W-1:0] portb_data, // output data
  input wire logic [W-1:0] portb_pin_i, // pin levels
  output logic [W-1:0] portb_pin_o, // pin output values
  output logic [W-1:0] portb_pin_oe, // pin output enables
  output logic [W-1:0] portb_level, // sampled levels
  input wire logic modem_out_en_bit1, // modem output enable bit 1
  input wire logic modem_out_en_bit0, // modem output enable bit 0
  output logic modem_output_enable_term, // modem outputs on
  input wire logic request_to_send_out, // request-to-send value
  input wire logic terminal_ready_out, // terminal-ready value
  output logic clear_to_send_in, // clear-to-send level
  output logic data_set_ready_in, // data-set-ready level
  output logic carrier_detect_in, // carrier-detect level
  input wire logic pwm_ch1_output_enable, // pwm 1 output on
  input wire logic pwm_ch1_out // pwm 1 value
);

  // per-port select vectors
  logic [W-1:0] p8_fsel, p8_fout, p8_foe, p8_od;
  logic [W-1:0] p9_fsel, p9_fout, p9_foe, p9_od;
  logic [W-1:0] pa_fsel, pa_fout, pa_foe, pa_od;
  logic [W-1:0] pb_fsel, pb_fout, pb_foe, pb_od;
  logic host_en; // host-bus-enable term
  logic modem_en; // modem output enable term
  logic ext_clk_sel; // pin 9-6 is the external clock input

  // ==========================================================================
  // enable terms
  // ==========================================================================
  // host functions share the two host pins
  assign host_en = serial_fifo_host_enable | host_channel4_enable
    | host_channel3_enable | host_channel2_enable
    | host_channel1_enable;

  // bit 0 set keeps modem outputs off in both modes
  assign modem_en = (~serial_fifo_host_enable & modem_out_en_bit1
    & ~modem_out_en_bit0)
    | (serial_fifo_host_enable & ~modem_out_en_bit0);

  // direction output wins over the external clock input
  assign ext_clk_sel = (port9_dir[pfs_pkg::P9_CLK] != pfs_pkg::DIR_OUTPUT)
    & ~ext_clock_select & ext_clock_enable;

  // ==========================================================================
  // port 8 selection
  // ==========================================================================
  // bits 7..5 stay plain port pins here
  always_comb begin
    p8_fsel = '0;
    p8_fout = '0;
    p8_foe = '0;
    p8_od = '0;
    // transmit output takes the pin regardless of direction
    p8_fsel[pfs_pkg::P8_TXD] = serial1_transmit_enable;
    p8_fout[pfs_pkg::P8_TXD] = serial1_transmit_out;
    p8_foe[pfs_pkg::P8_TXD] = 1'b1;
    // power-down is input only, buffer off
    p8_fsel[pfs_pkg::P8_PWRDN] = host_en;
    // clock-run direction comes from the host logic
    p8_fsel[pfs_pkg::P8_HOST_CLOCK_RUN_IO] = host_en;
    p8_fout[pfs_pkg::P8_HOST_CLOCK_RUN_IO] = host_clock_run_out;
    p8_foe[pfs_pkg::P8_HOST_CLOCK_RUN_IO] = host_clock_run_oe;
    // gate a20 output
    p8_fsel[pfs_pkg::P8_GATE_A20_OUT] = fast_gate_a20_enable;
    p8_fout[pfs_pkg::P8_GATE_A20_OUT] = gate_a20_out;
    p8_foe[pfs_pkg::P8_GATE_A20_OUT] = 1'b1;
    // power event output
    p8_fsel[pfs_pkg::P8_PME] = power_event_enable;
    p8_fout[pfs_pkg::P8_PME] = power_event_out;
    p8_foe[pfs_pkg::P8_PME] = 1'b1;
  end

  // ==========================================================================
  // port 9 selection
  // ==========================================================================
  // bits 5..0 are plain port pins with interrupt feeds
  always_comb begin
    p9_fsel = '0;
    p9_fout = '0;
    p9_foe = '0;
    p9_od = '0;
    // i2c data: buffer only ever pulls low
    p9_fsel[pfs_pkg::P9_SDA] = i2c0_enable;
    p9_fout[pfs_pkg::P9_SDA] = i2c0_data_out;
    p9_foe[pfs_pkg::P9_SDA] = 1'b1;
    p9_od[pfs_pkg::P9_SDA] = i2c0_enable;
    // direction 1 drives the clock output; external clock is input only
    p9_fsel[pfs_pkg::P9_CLK] = ext_clk_sel
      | (port9_dir[pfs_pkg::P9_CLK] == pfs_pkg::DIR_OUTPUT);
    p9_fout[pfs_pkg::P9_CLK] = clock_out_value;
    p9_foe[pfs_pkg::P9_CLK] = ~ext_clk_sel;
  end

  // ==========================================================================
  // port a selection
  // ==========================================================================
  // ps/2 pins are open drain; i2c format makes a-7..a-4 drive-low only
  always_comb begin
    pa_fsel = '0;
    pa_fout = '0;
    pa_foe = '0;
    pa_od = '0;
    for (int i = pfs_pkg::PA_OD_LO; i <= pfs_pkg::PA_OD_HI; i++) begin
      pa_od[i] = i2c_pin_format_select;
    end
    for (int i = pfs_pkg::PA_PS2_LO; i <= pfs_pkg::PA_PS2_HI; i++) begin
      pa_fsel[i] = ps2_pin_enable;
      pa_fout[i] = ps2_out[i - pfs_pkg::PA_PS2_LO];
      pa_foe[i] = 1'b1;
      if (ps2_pin_enable) begin // open drain while ps/2 owns it
        pa_od[i] = 1'b1;
      end
    end
  end

  // ==========================================================================
  // port b selection
  // ==========================================================================
  // cts and dsr pins stay plain ports
  always_comb begin
    pb_fsel = '0;
    pb_fout = '0;
    pb_foe = '0;
    pb_od = '0;
    // modem control outputs
    pb_fsel[pfs_pkg::PB_RTS] = modem_en;
    pb_fout[pfs_pkg::PB_RTS] = request_to_send_out;
    pb_foe[pfs_pkg::PB_RTS] = 1'b1;
    pb_fsel[pfs_pkg::PB_DTR] = modem_en;
    pb_fout[pfs_pkg::PB_DTR] = terminal_ready_out;
    pb_foe[pfs_pkg::PB_DTR] = 1'b1;
    // pwm only reaches the pin with direction 1
    pb_fsel[pfs_pkg::PB_DCD] = pwm_ch1_output_enable
      & (portb_dir[pfs_pkg::PB_DCD] == pfs_pkg::DIR_OUTPUT);
    pb_fout[pfs_pkg::PB_DCD] = pwm_ch1_out;
    pb_foe[pfs_pkg::PB_DCD] = 1'b1;
  end

  // ==========================================================================
  // pin cells
  // ==========================================================================
  pfs_pin_cell #(.W(W)) u_port8 (
    .clk(clk),
    .srst(srst),
    .dir(port8_dir),
    .data(port8_data),
    .fsel(p8_fsel),
    .fout(p8_fout),
    .foe(p8_foe),
    .od(p8_od),
    .pin_i(port8_pin_i),
    .pin_o(port8_pin_o),
    .pin_oe(port8_pin_oe),
    .level(port8_level)
  );

  pfs_pin_cell #(.W(W)) u_port9 (
    .clk(clk),
    .srst(srst),
    .dir(port9_dir),
    .data(port9_data),
    .fsel(p9_fsel),
    .fout(p9_fout),
    .foe(p9_foe),
    .od(p9_od),
    .pin_i(port9_pin_i),
    .pin_o(port9_pin_o),
    .pin_oe(port9_pin_oe),
    .level(port9_level)
  );

  pfs_pin_cell #(.W(W)) u_porta (
    .clk(clk),
    .srst(srst),
    .dir(porta_dir),
    .data(porta_data),
    .fsel(pa_fsel),
    .fout(pa_fout),
    .foe(pa_foe),
    .od(pa_od),
    .pin_i(porta_pin_i),
    .pin_o(porta_pin_o),
    .pin_oe(porta_pin_oe),
    .level(porta_level)
  );

  pfs_pin_cell #(.W(W)) u_portb (
    .clk(clk),
    .srst(srst),
    .dir(portb_dir),
    .data(portb_data),
    .fsel(pb_fsel),
    .fout(pb_fout),
    .foe(pb_foe),
    .od(pb_od),
    .pin_i(portb_pin_i),
    .pin_o(portb_pin_o),
    .pin_oe(portb_pin_oe),
    .level(portb_level)
  );

  // ==========================================================================
  // enable term status
  // ==========================================================================
  // registered so the status ports change in step with the pins
  always_ff @(posedge clk) begin
    if (srst) begin
      host_bus_enable_term <= pfs_pkg::STATUS_RST;
      modem_output_enable_term <= pfs_pkg::STATUS_RST;
    end else begin
      host_bus_enable_term <= host_en;
      modem_output_enable_term <= modem_en;
    end
  end

  // ==========================================================================
  // interrupt feeds
  // ==========================================================================
  // feeds use the raw pin level; the port read path has its own sample
  always_ff @(posedge clk) begin
    if (srst) begin
      irq_in <= {16{pfs_pkg::FEED_IDLE}};
    end else begin
      irq_in <= {16{pfs_pkg::FEED_IDLE}};
      if (~irq_pin_select[pfs_pkg::IRQ_P84] & irq_enable[pfs_pkg::IRQ_P84])
      begin
        irq_in[pfs_pkg::IRQ_P84] <= port8_pin_i[pfs_pkg::P8_TXD];
      end
      if (~irq_pin_select[pfs_pkg::IRQ_P97] & irq_enable[pfs_pkg::IRQ_P97])
      begin
        irq_in[pfs_pkg::IRQ_P97] <= port9_pin_i[pfs_pkg::P9_SDA];
      end
      for (int n = 0; n < pfs_pkg::P9_IRQ_N; n++) begin
        if (~irq_pin_select[pfs_pkg::P9_IRQ[n]]
            & irq_enable[pfs_pkg::P9_IRQ[n]]) begin
          irq_in[pfs_pkg::P9_IRQ[n]] <= port9_pin_i[n];
        end
      end
    end
  end

  // ==========================================================================
  // key-scan feeds
  // ==========================================================================
  // a masked input rests high so it never reads as a key press
  always_ff @(posedge clk) begin
    if (srst) begin
      keyscan_input <= {8{pfs_pkg::FEED_IDLE}};
    end else begin
      for (int i = 0; i < 8; i++) begin
        if (~keyscan_mask_bit[pfs_pkg::KEY_BASE + i]) begin // unmasked
          keyscan_input[pfs_pkg::KEY_BASE + i] <= porta_pin_i[i];
        end else begin
          keyscan_input[pfs_pkg::KEY_BASE + i] <= pfs_pkg::FEED_IDLE;
        end
      end
    end
  end

  // ==========================================================================
  // host and clock feeds
  // ==========================================================================
  // unselected host inputs rest inactive high
  always_ff @(posedge clk) begin
    if (srst) begin
      host_power_down_in <= pfs_pkg::FEED_IDLE;
      host_clock_run_in <= pfs_pkg::FEED_IDLE;
      ext_clock_in <= pfs_pkg::CLK_IDLE;
      i2c0_data_line <= pfs_pkg::FEED_IDLE;
    end else begin
      host_power_down_in <= host_en ? port8_pin_i[pfs_pkg::P8_PWRDN]
        : pfs_pkg::FEED_IDLE;
      host_clock_run_in <= host_en ? port8_pin_i[pfs_pkg::P8_HOST_CLOCK_RUN_IO]
        : pfs_pkg::FEED_IDLE;
      ext_clock_in <= ext_clk_sel ? port9_pin_i[pfs_pkg::P9_CLK]
        : pfs_pkg::CLK_IDLE;
      i2c0_data_line <= i2c0_enable ? port9_pin_i[pfs_pkg::P9_SDA]
        : pfs_pkg::FEED_IDLE;
    end
  end

  // ==========================================================================
  // ps/2 and modem feeds
  // ==========================================================================
  // modem status inputs follow their pins whatever the direction
  always_ff @(posedge clk) begin
    if (srst) begin
      ps2_line_in <= {4{pfs_pkg::FEED_IDLE}};
      clear_to_send_in <= pfs_pkg::FEED_IDLE;
      data_set_ready_in <= pfs_pkg::FEED_IDLE;
      carrier_detect_in <= pfs_pkg::FEED_IDLE;
    end else begin
      for (int i = 0; i < 4; i++) begin
        ps2_line_in[i] <= ps2_pin_enable
          ? porta_pin_i[pfs_pkg::PA_PS2_LO + i]
          : pfs_pkg::FEED_IDLE;
      end
      clear_to_send_in <= portb_pin_i[pfs_pkg::PB_CTS];
      data_set_ready_in <= portb_pin_i[pfs_pkg::PB_DSR];
      carrier_detect_in <= portb_pin_i[pfs_pkg::PB_DCD];
    end
  end

endmodule : pfs_port_select

// ==== pfs_partner.sv ====
`timescale 1ns/1ps
// ==========================================================================
// far side: each pin resolves against a pull-up or an external level
// ==========================================================================
module pfs_partner #(
  parameter int W = 32 // pins modelled
) (
  input wire logic [W-1:0] o, // device output value
  input wire logic [W-1:0] oe, // device output enable
  input wire logic [W-1:0] ext, // external level, 1 when only pulled up
  output wire logic [W-1:0] pin_i // resolved wire level
);
  // a driving device wins; a released pin shows ext, never its last value
  assign pin_i = (oe & o) | (~oe & ext);
endmodule : pfs_partner

// ==== pfs_monitor.sv ====
`timescale 1ns/1ps
// ==========================================================================
// checker on the pin-function select ports
// ==========================================================================
module pfs_monitor (
  input wire logic clk, srst, // clock, sync reset
  input wire logic [7:0] port8_pin_o, port8_pin_oe, port9_pin_o, port9_pin_oe,
  input wire logic [7:0] porta_pin_o, porta_pin_oe, portb_pin_oe,
  input wire logic serial1_transmit_enable, serial1_transmit_out,
  input wire logic serial_fifo_host_enable, host_channel4_enable,
  input wire logic host_channel3_enable, host_channel2_enable,
  input wire logic host_channel1_enable, host_bus_enable_term,
  input wire logic fast_gate_a20_enable, gate_a20_out, i2c0_enable,
  input wire logic ps2_pin_enable, modem_out_en_bit1, modem_out_en_bit0,
  input wire logic modem_output_enable_term
);
  // all outputs are registered, so most relations look one edge ahead
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);
  tx_pin_a: assert property (serial1_transmit_enable |=>
    port8_pin_oe[4] && port8_pin_o[4] == $past(serial1_transmit_out))
    else $error("transmit pin not driven");
  host_term_a: assert property ((serial_fifo_host_enable ||
    host_channel4_enable || host_channel3_enable || host_channel2_enable
    || host_channel1_enable) |=> host_bus_enable_term)
    else $error("host enable term missing");
  host_pin_a: assert property (host_bus_enable_term |->
    !port8_pin_oe[3]) else $error("power-down pin driven");
  a20_pin_a: assert property (fast_gate_a20_enable |=>
    port8_pin_oe[1] && port8_pin_o[1] == $past(gate_a20_out))
    else $error("gate a20 pin wrong");
  sda_low_a: assert property (i2c0_enable |=>
    !(port9_pin_oe[7] && port9_pin_o[7])) else $error("i2c data driven high");
  ps2_low_a: assert property (ps2_pin_enable |=>
    (porta_pin_oe[5:2] & porta_pin_o[5:2]) == 4'h0)
    else $error("ps2 pin driven high");
  modem_term_a: assert property ((!serial_fifo_host_enable &&
    modem_out_en_bit1 && !modem_out_en_bit0 || serial_fifo_host_enable &&
    !modem_out_en_bit0) |=> modem_output_enable_term)
    else $error("modem term missing");
  modem_pins_a: assert property (modem_output_enable_term |->
    portb_pin_oe[7] && portb_pin_oe[5]) else $error("modem pins undriven");
endmodule : pfs_monitor

bind pfs_port_select pfs_monitor u_mon (.*);

// ==== tb_top.sv ====
`timescale 1ns/1ps
// ==========================================================================
// testbench: stimulus at rising edges, checks after outputs settle
// ==========================================================================
module tb_top;
  logic clk = 1'b0, srst = 1'b1;
  logic [7:0] port8_dir, port8_data, port8_pin_o, port8_pin_oe, port8_level;
  logic [7:0] port9_dir, port9_data, port9_pin_o, port9_pin_oe, port9_level;
  logic [7:0] porta_dir, porta_data, porta_pin_o, porta_pin_oe, porta_level;
  logic [7:0] portb_dir, portb_data, portb_pin_o, portb_pin_oe, portb_level;
  wire [7:0] port8_pin_i, port9_pin_i, porta_pin_i, portb_pin_i;
  logic serial1_transmit_enable, serial1_transmit_out, serial_fifo_host_enable;
  logic host_channel4_enable, host_channel3_enable, host_channel2_enable;
  logic host_channel1_enable, host_clock_run_out, host_clock_run_oe;
  logic fast_gate_a20_enable, gate_a20_out, power_event_enable;
  logic power_event_out, i2c0_enable, i2c0_data_out, ext_clock_select;
  logic ext_clock_enable, clock_out_value, i2c_pin_format_select;
  logic ps2_pin_enable, modem_out_en_bit1, modem_out_en_bit0;
  logic request_to_send_out, terminal_ready_out, pwm_ch1_output_enable;
  logic pwm_ch1_out, host_bus_enable_term, host_power_down_in;
  logic host_clock_run_in, i2c0_data_line, ext_clock_in;
  logic modem_output_enable_term, clear_to_send_in, data_set_ready_in;
  logic carrier_detect_in;
  logic [15:0] irq_pin_select, irq_enable, irq_in;
  logic [15:8] keyscan_mask_bit, keyscan_input;
  logic [3:0] ps2_out, ps2_line_in;
  logic [31:0] ext = 32'hffffffff; // far-side levels, pulled up by default
  int miscompares = 0, checked = 0;
  bit [2:0] m;
  always #10 clk = ~clk;
  pfs_port_select uut (.*);
  pfs_partner #(.W(32)) u_far (.o({portb_pin_o, porta_pin_o, port9_pin_o,
    port8_pin_o}), .oe({portb_pin_oe, porta_pin_oe, port9_pin_oe,
    port8_pin_oe}), .ext(ext), .pin_i({portb_pin_i, porta_pin_i,
    port9_pin_i, port8_pin_i}));
  // one comparison kind: four-state values up to 16 bits
  task chk(string n, logic [15:0] e, logic [15:0] g);
    checked++;
    if (g !== e) begin
      miscompares++;
      $display("[FAIL] %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  // two edges: one to register inputs, one for pin-level feeds
  task go;
    repeat (2) @(posedge clk);
    #1;
  endtask : go
  task summarize;
    $display("checked %0d miscompares %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : summarize
  task sc_port8;
    @(posedge clk) {serial1_transmit_enable, serial1_transmit_out} <= 2'b11;
    {fast_gate_a20_enable, gate_a20_out} <= 2'b11;
    go;
    chk("p8 oe", 16'h12, port8_pin_oe);
    chk("p8 o", 16'h12, port8_pin_o);
    @(posedge clk) serial1_transmit_enable <= 1'b0;
    irq_enable[3] <= 1'b1;
    ext[4] <= 1'b0;
    go;
    chk("irq3", 16'hfff7, irq_in);
  endtask : sc_port8
  task sc_host;
    for (int i = 0; i < 5; i++) begin
      @(posedge clk) {port8_dir[3], ext[3]} <= 2'b10;
      {serial_fifo_host_enable, host_channel4_enable, host_channel3_enable,
        host_channel2_enable, host_channel1_enable} <= 5'h1 << i;
      go;
      chk("host", 16'h5, {host_bus_enable_term, host_power_down_in,
        host_clock_run_in});
      chk("p83 oe", 16'h0, port8_pin_oe[3]);
    end
  endtask : sc_host
  task sc_i2c;
    @(posedge clk) {i2c0_enable, i2c0_data_out, irq_enable[15]} <= 3'b111;
    port9_dir[7] <= 1'b1;
    go;
    chk("sda release", 16'h0, port9_pin_oe[7]);
    @(posedge clk) i2c0_data_out <= 1'b0;
    go;
    chk("sda pull", 16'h2, {port9_pin_oe[7], port9_pin_o[7]});
    chk("irq15", 16'h0, irq_in[15]);
    chk("sda line", 16'h0, i2c0_data_line);
  endtask : sc_i2c
  task sc_ps2;
    @(posedge clk) {ps2_pin_enable, ps2_out} <= 5'h15;
    {ext_clock_enable, ext[14]} <= 2'b11;
    go;
    chk("ps2 oe", 16'ha, porta_pin_oe[5:2]);
    chk("key13..10", 16'h5, keyscan_input[13:10]);
    chk("ps2 in", 16'h5, ps2_line_in);
    chk("pa lvl", 16'hd7, porta_level);
    chk("ext clock", 16'h1, ext_clock_in);
  endtask : sc_ps2
  task sc_modem;
    for (int i = 0; i < 8; i++) begin
      m = i[2:0];
      @(posedge clk) {serial_fifo_host_enable, modem_out_en_bit1,
        modem_out_en_bit0} <= m;
      go;
      chk("modem term", 16'((!m[2] & m[1] & !m[0]) | (m[2] & !m[0])),
        modem_output_enable_term);
      chk("rts dtr oe", 16'({2{!m[0] & (m[1] | m[2])}}),
        {portb_pin_oe[7], portb_pin_oe[5]});
    end
    @(posedge clk) {portb_dir[3], pwm_ch1_output_enable, pwm_ch1_out} <= 3'h7;
    {ext[30], ext[27]} <= 2'b00;
    go;
    chk("pwm pin", 16'h3, {portb_pin_oe[3], portb_pin_o[3]});
    chk("cts dsr dcd", 16'h3, {clear_to_send_in, data_set_ready_in,
      carrier_detect_in});
  endtask : sc_modem
  initial begin
    {port8_dir, port8_data, port9_dir, port9_data} <= '0;
    {porta_dir, porta_data, portb_dir, portb_data} <= '0;
    {serial1_transmit_enable, serial1_transmit_out, serial_fifo_host_enable,
      host_channel4_enable, host_channel3_enable, host_channel2_enable,
      host_channel1_enable, host_clock_run_out, host_clock_run_oe,
      fast_gate_a20_enable, gate_a20_out, power_event_enable, power_event_out,
      i2c0_enable, i2c0_data_out, ext_clock_select, ext_clock_enable,
      clock_out_value, i2c_pin_format_select, ps2_pin_enable,
      modem_out_en_bit1, modem_out_en_bit0, request_to_send_out,
      terminal_ready_out, pwm_ch1_output_enable, pwm_ch1_out} <= '0;
    {irq_pin_select, irq_enable, keyscan_mask_bit, ps2_out} <= '0;
    repeat (6) @(posedge clk);
    srst <= 1'b0;
    go;
    chk("idle oe", 16'h0, {port8_pin_oe, port9_pin_oe});
    sc_port8;
    sc_host;
    sc_i2c;
    sc_ps2;
    sc_modem;
    summarize;
  end
  // a hang past the expected 65 cycles ends the run as a failure
  initial begin
    #20us;
    miscompares++;
    summarize;
  end
endmodule : tb_top
